/* File: src/wdt_pkg.sv */
// Package with register map, field layout, reset values and types of the watchdog timer.
package wdt_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PRE_W = 13;
  localparam int CNT_W = 8;
  localparam int TAP_W = 3;
  localparam int IRQ_W = 2;
  localparam int HOLD_W = 4;

  // Byte offsets of the registers on the APB side.
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_AUTOLOAD = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_FEED_FIRST = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_FEED_SECOND = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_COUNTER = 8'h18;

  // Field positions inside the control register.
  localparam int CTRL_TAP_LSB = 5;
  localparam int CTRL_TAP_MSB = 7;
  localparam int CTRL_RUN_BIT = 2;
  localparam int CTRL_TOF_BIT = 1;

  // Event bits of the interrupt status and mask registers.
  localparam int IRQ_UNDERFLOW_BIT = 0;
  localparam int IRQ_FEEDFAIL_BIT = 1;

  // Reset values.
  localparam logic [TAP_W-1:0] TAP_RESET = 3'h7;
  localparam logic RUN_RESET = 1'b1;
  localparam logic [CNT_W-1:0] AUTOLOAD_RESET = 8'h00;
  localparam logic [PRE_W-1:0] PRE_CLEAR = 13'h0000;
  localparam logic [IRQ_W-1:0] IRQ_NONE = 2'h0;

  // Feed keys and the smallest divisor as a power of two (tap 0 divides by 32).
  localparam logic [7:0] FEED_KEY_FIRST = 8'hA5;
  localparam logic [7:0] FEED_KEY_SECOND = 8'h5A;
  localparam int TAP_BASE_SHIFT = 5;

  // Length of the system reset request in clk cycles.
  localparam logic [HOLD_W-1:0] RESET_HOLD_CYCLES = 4'h8;

  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  typedef enum logic {FEED_IDLE, FEED_ARMED} feed_state_t;

endpackage : wdt_pkg

/* File: src/wdt_link_if.sv */
// Interface joining the watchdog core with its prescaler and feed checker.
`timescale 1ns/100ps
interface wdt_link_if;
  logic tick;
  logic run;
  logic [wdt_pkg::TAP_W-1:0] tap;
  logic clear;
  logic decrement;
  logic busAccess;
  logic busWrite;
  logic hitFirst;
  logic hitSecond;
  logic [7:0] wdata;
  logic feedOk;
  logic feedFail;

  modport core (
    output tick, run, tap, clear, busAccess, busWrite, hitFirst, hitSecond, wdata,
    input decrement, feedOk, feedFail
  );
  modport prescale (input tick, run, tap, clear, output decrement);
  modport feed (input busAccess, busWrite, hitFirst, hitSecond, wdata, output feedOk, feedFail);
endinterface : wdt_link_if

/* File: src/wdt_prescaler.sv */
// Thirteen-bit watchdog prescaler with a selectable decrement tap.
`timescale 1ns/100ps
module wdt_prescaler (
  input wire logic clk,
  input wire logic resetn,
  wdt_link_if.prescale link
);

  typedef struct packed {
    logic [wdt_pkg::PRE_W-1:0] count;
  } pre_state_t;

  pre_state_t state;
  pre_state_t next_state;

  // Low bits that must all be one for the selected tap to fire on the next tick.
  function automatic logic [wdt_pkg::PRE_W-1:0] tapMask(input logic [wdt_pkg::TAP_W-1:0] tap);
    logic [wdt_pkg::PRE_W:0] one;
    one = (wdt_pkg::PRE_W+1)'(1) << (int'(tap) + wdt_pkg::TAP_BASE_SHIFT);
    return wdt_pkg::PRE_W'(one - 1'b1);
  endfunction : tapMask

  logic [wdt_pkg::PRE_W-1:0] mask;

  always_comb begin
    mask = tapMask(link.tap);
    next_state = state;
    if (link.clear) begin
      next_state.count = wdt_pkg::PRE_CLEAR;
    end else if (link.tick && link.run) begin
      next_state.count = state.count + 1'b1;
    end
  end

  assign link.decrement = link.tick && link.run && ((state.count & mask) == mask);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state.count <= wdt_pkg::PRE_CLEAR;
    end else begin
      state <= next_state;
    end
  end

endmodule : wdt_prescaler

/* File: src/wdt_feed_check.sv */
// Checker of the two-write feed sequence.
`timescale 1ns/100ps
module wdt_feed_check (
  input wire logic clk,
  input wire logic resetn,
  wdt_link_if.feed link
);

  typedef struct packed {
    wdt_pkg::feed_state_t phase;
  } feed_reg_t;

  feed_reg_t state;
  feed_reg_t next_state;
  logic firstGood;
  logic secondGood;

  always_comb begin
    next_state = state;
    firstGood = link.busWrite && link.hitFirst && (link.wdata == wdt_pkg::FEED_KEY_FIRST);
    secondGood = link.busWrite && link.hitSecond && (link.wdata == wdt_pkg::FEED_KEY_SECOND);
    link.feedOk = 1'b0;
    link.feedFail = 1'b0;
    unique case (state.phase)
      wdt_pkg::FEED_IDLE: begin
        if (link.busAccess && firstGood) begin
          next_state.phase = wdt_pkg::FEED_ARMED;
        end
      end
      wdt_pkg::FEED_ARMED: begin
        if (link.busAccess) begin
          // Any access other than the correct second write breaks the feed.
          link.feedOk = secondGood;
          link.feedFail = !secondGood;
          next_state.phase = wdt_pkg::FEED_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state.phase <= wdt_pkg::FEED_IDLE;
    end else begin
      state <= next_state;
    end
  end

endmodule : wdt_feed_check

/* File: src/watchdog_reset_timer.sv */
// Watchdog reset timer with APB register access, feed sequence and interrupt.
`timescale 1ns/100ps
//
// Summary of operation
// - Watchdog runs after every reset; software must stop it if unwanted.
// - A 13-bit prescaler drives an 8-bit down-counting main counter.
// - Prescaler counts timer clock; a tap among its upper bits decrements the counter.
// - Tap codes 0 to 7 divide by 32, 64, 128 up to 4096.
// - Decrement at zero signals underflow and reloads from the autoload value.
// - Autoload accepts 0x00 to 0xFF and every autoload clears the prescaler.
// - The main counter cannot be written directly, only autoloaded.
// - Writing 0xA5 then 0x5A to the two feed registers autoloads the counter.
// - Correct first write followed by a wrong second value resets immediately.
// - Any other register access between the feed writes fails and resets.
// - Tap and run writes are stored and take effect only after a valid feed.
// - External reset: run on, autoload zero, flag clear, largest tap, autoload.
// - An underflow coinciding with external reset leaves the timeout flag clear.
// - Underflow autoloads, sets the flag, keeps settings and requests system reset.
// - Software can read and clear the timeout flag.
// - Control bits 7..5 tap, bit 2 run, bit 1 timeout flag.
// - Timeout is timer-clock prescale times divisor times autoload plus one.
module watchdog_reset_timer (
  input wire logic clk,
  input wire logic resetn,
  input wire logic timerClock,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wdt_pkg::ADDR_W-1:0] paddr,
  input wire logic [wdt_pkg::DATA_W-1:0] pwdata,
  output logic [wdt_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic systemReset,
  output logic irq
);

  typedef struct packed {
    logic tclkMeta;
    logic tclkSync;
    logic tclkPrev;
    logic [wdt_pkg::TAP_W-1:0] tapPending;
    logic runPending;
    logic [wdt_pkg::TAP_W-1:0] tap;
    logic run;
    logic [wdt_pkg::CNT_W-1:0] autoload;
    logic [wdt_pkg::CNT_W-1:0] counter;
    logic timeoutFlag;
    logic [wdt_pkg::IRQ_W-1:0] irqStatus;
    logic [wdt_pkg::IRQ_W-1:0] irqMask;
    logic [wdt_pkg::HOLD_W-1:0] holdCount;
    logic resetOut;
    logic [wdt_pkg::DATA_W-1:0] readData;
    logic readErr;
  } core_state_t;

  core_state_t state;
  core_state_t next_state;

  wdt_link_if link ();

  wdt_prescaler u_prescaler (
    .clk(clk),
    .resetn(resetn),
    .link(link.prescale)
  );

  wdt_feed_check u_feed (
    .clk(clk),
    .resetn(resetn),
    .link(link.feed)
  );

  // Tells whether an address names one of the mapped registers.
  function automatic logic isMapped(input logic [wdt_pkg::ADDR_W-1:0] addr);
    return (addr == wdt_pkg::OFF_CONTROL) || (addr == wdt_pkg::OFF_AUTOLOAD) ||
           (addr == wdt_pkg::OFF_FEED_FIRST) || (addr == wdt_pkg::OFF_FEED_SECOND) ||
           (addr == wdt_pkg::OFF_IRQ_STATUS) || (addr == wdt_pkg::OFF_IRQ_MASK) ||
           (addr == wdt_pkg::OFF_COUNTER);
  endfunction : isMapped

  // Control register image: pending tap and run, live timeout flag.
  function automatic logic [wdt_pkg::DATA_W-1:0] controlImage(input core_state_t s);
    logic [wdt_pkg::DATA_W-1:0] v;
    v = wdt_pkg::DATA_ZERO;
    v[wdt_pkg::CTRL_TAP_MSB:wdt_pkg::CTRL_TAP_LSB] = s.tapPending;
    v[wdt_pkg::CTRL_RUN_BIT] = s.runPending;
    v[wdt_pkg::CTRL_TOF_BIT] = s.timeoutFlag;
    return v;
  endfunction : controlImage

  logic setupPhase;
  logic accessPhase;
  logic writeAccess;
  logic underflow;
  logic autoloadNow;
  logic watchdogEvent;
  logic [wdt_pkg::IRQ_W-1:0] irqSet;
  logic [wdt_pkg::IRQ_W-1:0] irqClear;

  always_comb begin
    next_state = state;
    setupPhase = psel && !penable;
    accessPhase = psel && penable;
    writeAccess = accessPhase && pwrite;
    irqClear = wdt_pkg::IRQ_NONE;

    // Timer clock arrives from a pin; only the second and third stages are looked at.
    next_state.tclkMeta = timerClock;
    next_state.tclkSync = state.tclkMeta;
    next_state.tclkPrev = state.tclkSync;

    // Main counter: decrement on each tap pulse, reload at zero.
    underflow = link.decrement && (state.counter == '0);
    autoloadNow = underflow || link.feedOk;
    watchdogEvent = underflow || link.feedFail;
    if (autoloadNow) begin
      next_state.counter = state.autoload;
    end else if (link.decrement) begin
      next_state.counter = state.counter - 1'b1;
    end

    // A valid feed commits the stored control settings.
    if (link.feedOk) begin
      next_state.tap = state.tapPending;
      next_state.run = state.runPending;
    end

    // Register writes take effect at the completing access edge.
    if (writeAccess) begin
      unique case (paddr)
        wdt_pkg::OFF_CONTROL: begin
          next_state.tapPending = pwdata[wdt_pkg::CTRL_TAP_MSB:wdt_pkg::CTRL_TAP_LSB];
          next_state.runPending = pwdata[wdt_pkg::CTRL_RUN_BIT];
          if (!pwdata[wdt_pkg::CTRL_TOF_BIT]) begin
            next_state.timeoutFlag = 1'b0;
          end
        end
        wdt_pkg::OFF_AUTOLOAD: begin
          next_state.autoload = pwdata[wdt_pkg::CNT_W-1:0];
        end
        wdt_pkg::OFF_IRQ_STATUS: begin
          irqClear = pwdata[wdt_pkg::IRQ_W-1:0];
        end
        wdt_pkg::OFF_IRQ_MASK: begin
          next_state.irqMask = pwdata[wdt_pkg::IRQ_W-1:0];
        end
        default: begin
          // Feed registers are handled by the checker; the counter is read-only.
          next_state.irqMask = state.irqMask;
        end
      endcase
    end

    // The hardware set wins over a software clear in the same cycle.
    if (watchdogEvent) begin
      next_state.timeoutFlag = 1'b1;
    end
    irqSet = wdt_pkg::IRQ_NONE;
    irqSet[wdt_pkg::IRQ_UNDERFLOW_BIT] = underflow;
    irqSet[wdt_pkg::IRQ_FEEDFAIL_BIT] = link.feedFail;
    next_state.irqStatus = (state.irqStatus & ~irqClear) | irqSet;

    // System reset request is stretched so the rest of the chip sees it.
    if (watchdogEvent) begin
      next_state.holdCount = wdt_pkg::RESET_HOLD_CYCLES;
    end else if (state.holdCount != '0) begin
      next_state.holdCount = state.holdCount - 1'b1;
    end
    next_state.resetOut = watchdogEvent || (state.holdCount > 1'b1);

    // Read data is captured in the setup phase so the answer comes from flops.
    next_state.readErr = 1'b0;
    if (setupPhase) begin
      next_state.readErr = !isMapped(paddr);
      next_state.readData = wdt_pkg::DATA_ZERO;
      if (!pwrite) begin
        unique case (paddr)
          wdt_pkg::OFF_CONTROL: begin
            next_state.readData = controlImage(state);
          end
          wdt_pkg::OFF_AUTOLOAD: begin
            next_state.readData[wdt_pkg::CNT_W-1:0] = state.autoload;
          end
          wdt_pkg::OFF_IRQ_STATUS: begin
            next_state.readData[wdt_pkg::IRQ_W-1:0] = state.irqStatus;
          end
          wdt_pkg::OFF_IRQ_MASK: begin
            next_state.readData[wdt_pkg::IRQ_W-1:0] = state.irqMask;
          end
          wdt_pkg::OFF_COUNTER: begin
            next_state.readData[wdt_pkg::CNT_W-1:0] = state.counter;
          end
          default: begin
            next_state.readData = wdt_pkg::DATA_ZERO;
          end
        endcase
      end
    end else if (!accessPhase) begin
      next_state.readData = wdt_pkg::DATA_ZERO;
    end
  end

  // Links to the prescaler and the feed checker.
  assign link.tick = state.tclkSync && !state.tclkPrev;
  assign link.run = state.run;
  assign link.tap = state.tap;
  assign link.clear = autoloadNow;
  assign link.busAccess = accessPhase;
  assign link.busWrite = pwrite;
  assign link.hitFirst = (paddr == wdt_pkg::OFF_FEED_FIRST);
  assign link.hitSecond = (paddr == wdt_pkg::OFF_FEED_SECOND);
  assign link.wdata = pwdata[7:0];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state.tclkMeta <= 1'b0;
      state.tclkSync <= 1'b0;
      state.tclkPrev <= 1'b0;
      state.tapPending <= wdt_pkg::TAP_RESET;
      state.runPending <= wdt_pkg::RUN_RESET;
      state.tap <= wdt_pkg::TAP_RESET;
      state.run <= wdt_pkg::RUN_RESET;
      state.autoload <= wdt_pkg::AUTOLOAD_RESET;
      state.counter <= wdt_pkg::AUTOLOAD_RESET;
      state.timeoutFlag <= 1'b0;
      state.irqStatus <= wdt_pkg::IRQ_NONE;
      state.irqMask <= wdt_pkg::IRQ_NONE;
      state.holdCount <= '0;
      state.resetOut <= 1'b0;
      state.readData <= wdt_pkg::DATA_ZERO;
      state.readErr <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // Zero wait states: every access phase completes in its first cycle.
  assign pready = 1'b1;
  assign prdata = state.readData;
  assign pslverr = accessPhase && state.readErr;
  assign systemReset = state.resetOut;
  assign irq = |(state.irqStatus & state.irqMask);

endmodule : watchdog_reset_timer

/* File: dv/wdt_props.sv */
// Checker of the watchdog port behaviour, bound to the top module.
`timescale 1ns/100ps
module wdt_props (
  input wire logic clk,
  input wire logic resetn,
  input wire logic timerClock,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wdt_pkg::ADDR_W-1:0] paddr,
  input wire logic [wdt_pkg::DATA_W-1:0] pwdata,
  input wire logic [wdt_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic systemReset,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic armed;
  logic acc;
  logic first;
  logic second;
  logic mapped;
  assign acc = psel && penable && pready;
  assign mapped = paddr <= 8'h18 && paddr[1:0] == 2'h0;
  assign first = pwrite && paddr == wdt_pkg::OFF_FEED_FIRST
    && pwdata[7:0] == wdt_pkg::FEED_KEY_FIRST;
  assign second = pwrite && paddr == wdt_pkg::OFF_FEED_SECOND
    && pwdata[7:0] == wdt_pkg::FEED_KEY_SECOND;
  // Any access after an armed first write ends the sequence, good or bad.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      armed <= 1'b0;
    end else if (acc) begin
      armed <= !armed && first;
    end
  end
  // Read data is flopped, so it stands for one more cycle after the access edge.
  property p_rdZero;
    !(psel && penable) && !$past(psel && penable) |-> prdata == 32'h0000_0000;
  endproperty
  a_rdZero: assert property (p_rdZero) else $error("read data not zero when idle");
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("access without ready");
  property p_errUnmapped; psel && penable && paddr > 8'h18 |-> pslverr; endproperty
  a_errUnmapped: assert property (p_errUnmapped) else $error("unmapped access not refused");
  property p_errMapped; pslverr |-> psel && penable && !mapped; endproperty
  a_errMapped: assert property (p_errMapped) else $error("error outside unmapped access");
  property p_resetLen; $rose(systemReset) |-> systemReset[*8] ##1 !systemReset; endproperty
  a_resetLen: assert property (p_resetLen) else $error("reset request too short");
  property p_feedFail; acc && armed && !second && mapped |=> systemReset; endproperty
  a_feedFail: assert property (p_feedFail) else $error("failed feed gave no reset");
  property p_goodFeed; acc && armed && second |=> !$rose(systemReset); endproperty
  a_goodFeed: assert property (p_goodFeed) else $error("good feed gave a reset");
  property p_rdNoErr; acc && mapped |-> !pslverr; endproperty
  a_rdNoErr: assert property (p_rdNoErr) else $error("mapped access refused");
  c_feed: cover property (acc && armed && second);
  c_reset: cover property ($rose(systemReset));
  c_err: cover property (acc && pslverr);
  c_irq: cover property ($rose(irq));
endmodule : wdt_props
bind watchdog_reset_timer wdt_props props_u (.clk(clk), .resetn(resetn),
  .timerClock(timerClock), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .systemReset(systemReset), .irq(irq));

/* File: dv/testbench.sv */
// Self-checking testbench of the watchdog reset timer.
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module testbench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic timerClock = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic systemReset;
  logic irq;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  watchdog_reset_timer dut_u (.clk(clk), .resetn(resetn), .timerClock(timerClock),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .systemReset(systemReset),
    .irq(irq));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  // A hang in any wait below is cut short here.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      complete_run();
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK("read data", e, rd)
  endtask : rdChk
  task automatic feed();
    apb(1'b1, wdt_pkg::OFF_FEED_FIRST, {24'h00_0000, wdt_pkg::FEED_KEY_FIRST});
    apb(1'b1, wdt_pkg::OFF_FEED_SECOND, {24'h00_0000, wdt_pkg::FEED_KEY_SECOND});
  endtask : feed
  task automatic tick(input int n);
    repeat (n) begin
      timerClock <= 1'b1;
      repeat (2) @(posedge clk);
      timerClock <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask : tick
  // Watches for a reset request over a span, then lets it run out.
  task automatic rstSeen(input logic e, input int span);
    logic seen;
    seen = 1'b0;
    repeat (span) begin
      @(posedge clk);
      if (systemReset === 1'b1) seen = 1'b1;
    end
    while (systemReset !== 1'b0) @(posedge clk);
    `CHK("systemReset", e, seen)
  endtask : rstSeen
  task automatic t_reset();
    rdChk(wdt_pkg::OFF_CONTROL, 32'h0000_00E4);
    rdChk(wdt_pkg::OFF_AUTOLOAD, 32'h0000_0000);
    `CHK("irq", 1'b0, irq)
    $display("test reset done");
  endtask : t_reset
  task automatic t_taps();
    for (int t = 0; t < 8; t++) begin
      apb(1'b1, wdt_pkg::OFF_CONTROL, {24'h00_0000, t[2:0], 5'h04});
      feed();
      tick((32 << t) - 1);
      rstSeen(1'b0, 4);
      tick(1);
      rstSeen(1'b1, 8);
    end
    rdChk(wdt_pkg::OFF_CONTROL, 32'h0000_00E6);
    $display("test taps done");
  endtask : t_taps
  task automatic t_load();
    apb(1'b1, wdt_pkg::OFF_CONTROL, 32'h0000_0004);
    apb(1'b1, wdt_pkg::OFF_AUTOLOAD, 32'h0000_0002);
    feed();
    tick(95);
    rstSeen(1'b0, 4);
    tick(1);
    rstSeen(1'b1, 8);
    rdChk(wdt_pkg::OFF_COUNTER, 32'h0000_0002);
    apb(1'b1, wdt_pkg::OFF_COUNTER, 32'h0000_0055);
    rdChk(wdt_pkg::OFF_COUNTER, 32'h0000_0002);
    $display("test load done");
  endtask : t_load
  task automatic t_flag();
    apb(1'b1, wdt_pkg::OFF_CONTROL, 32'h0000_0006);
    rdChk(wdt_pkg::OFF_CONTROL, 32'h0000_0006);
    apb(1'b1, wdt_pkg::OFF_CONTROL, 32'h0000_0004);
    rdChk(wdt_pkg::OFF_CONTROL, 32'h0000_0004);
    apb(1'b0, 8'h40, 32'h0000_0000);
    `CHK("pslverr", 1'b1, err)
    `CHK("unmapped data", 32'h0000_0000, rd)
    $display("test flag done");
  endtask : t_flag
  task automatic t_irq();
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, wdt_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    // The mask lands at the access edge, so irq is looked at one edge later.
    @(posedge clk);
    `CHK("irq", 1'b1, irq)
    apb(1'b1, wdt_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
    @(posedge clk);
    `CHK("irq cleared", 1'b0, irq)
    rdChk(wdt_pkg::OFF_IRQ_STATUS, 32'h0000_0000);
    $display("test irq done");
  endtask : t_irq
  task automatic t_fail();
    apb(1'b1, wdt_pkg::OFF_FEED_FIRST, 32'h0000_00A5);
    apb(1'b1, wdt_pkg::OFF_FEED_SECOND, 32'h0000_005B);
    rstSeen(1'b1, 3);
    rdChk(wdt_pkg::OFF_IRQ_STATUS, 32'h0000_0002);
    apb(1'b1, wdt_pkg::OFF_FEED_FIRST, 32'h0000_00A5);
    rdChk(wdt_pkg::OFF_AUTOLOAD, 32'h0000_0002);
    rstSeen(1'b1, 3);
    $display("test fail done");
  endtask : t_fail
  task automatic t_stop();
    apb(1'b1, wdt_pkg::OFF_CONTROL, 32'h0000_0000);
    rdChk(wdt_pkg::OFF_CONTROL, 32'h0000_0000);
    tick(96);
    rstSeen(1'b1, 8);
    feed();
    tick(200);
    rstSeen(1'b0, 8);
    rdChk(wdt_pkg::OFF_COUNTER, 32'h0000_0002);
    $display("test stop done");
  endtask : t_stop
  // A second external reset after an underflow has left the timeout flag set.
  task automatic t_rerun();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("reset request", 1'b0, systemReset)
    resetn <= 1'b1;
    rdChk(wdt_pkg::OFF_CONTROL, 32'h0000_00E4);
    rdChk(wdt_pkg::OFF_AUTOLOAD, 32'h0000_0000);
    rdChk(wdt_pkg::OFF_COUNTER, 32'h0000_0000);
    `CHK("irq", 1'b0, irq)
    $display("test rerun done");
  endtask : t_rerun
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_taps();
    t_load();
    t_flag();
    t_irq();
    t_fail();
    t_stop();
    t_rerun();
    complete_run();
  end
endmodule : testbench
